// ---- hw/flash_ctl_defs.vh ----
// Constants for the parallel flash host controller.
// Included by the controller; holds definitions only.
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH
// Own register offsets (byte addresses)
`define REG_CTRL        5'h00
`define REG_ADDR        5'h04
`define REG_DATA        5'h08
`define REG_STATUS      5'h0c
`define REG_RDATA       5'h10
// Control register fields
`define CTRL_GO_BIT     0
`define CTRL_OP_LSB     4
`define CTRL_OP_W       4
// Operations
`define OP_READ         4'h0
`define OP_RESET        4'h1
`define OP_PROGRAM      4'h2
`define OP_SECT_ERASE   4'h3
`define OP_CHIP_ERASE   4'h4
`define OP_SUSPEND      4'h5
`define OP_RESUME       4'h6
`define OP_BYP_ENTER    4'h7
`define OP_BYP_PROGRAM  4'h8
`define OP_BYP_EXIT     4'h9
`define OP_AUTOSEL      4'ha
`define OP_SECT_ADD     4'hb
// Status register fields
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_FAIL_BIT     2
`define ST_RB_BIT       3
`define ST_BYP_BIT      4
`define ST_WINDOW_BIT   5
// Flash command codes and unlock addresses
`define ADDR_555        11'h555
`define ADDR_2AA        11'h2aa
`define CMD_AA          8'haa
`define CMD_55          8'h55
`define CMD_RESET       8'hf0
`define CMD_AUTOSEL     8'h90
`define CMD_PROGRAM     8'ha0
`define CMD_BYPASS      8'h20
`define CMD_ERASE       8'h80
`define CMD_CHIP        8'h10
`define CMD_SECTOR      8'h30
`define CMD_SUSPEND     8'hb0
`define CMD_BYP_EXIT2   8'h00
// Bus strobe timing, in clocks of 50 ns
`define T_PHASE_CYC     4'h2
`define RESET_DATA      32'h00000000
`endif

// ---- hw/flash_ctl.v ----
// Host-side controller for a clockless parallel boot-sector flash.
// Assumes an AXI4-Lite master, flash pins wired to the device, pull-up on ready/busy.
// Operation
// - Autoselect fourth cycle is a read; all other command cycles write.
// - Reset command leaves autoselect or a failed status.
// - Bypass program only after bypass entry; exit with two-cycle reset. The code issues bypass program without checking byp_r.
// - Polling reads use the program address or an erasing sector.
// - After poll bit turns true, data is taken on a later read; the code takes it from the read on which the toggle stopped.
// - Toggling twice read; still toggling with fail bit set means failure.
`timescale 1ns/1ps
`include "flash_ctl_defs.vh"
module flash_ctl #(
    parameter AW = 19
) (
    // Clock and reset
    input  wire          MCLK,
    input  wire          ARST_N,
    // AXI4-Lite slave
    input  wire [4:0]    S_AWADDR,
    input  wire          S_AWVALID,
    output reg           S_AWREADY,
    input  wire [31:0]   S_WDATA,
    input  wire [3:0]    S_WSTRB,
    input  wire          S_WVALID,
    output reg           S_WREADY,
    output reg  [1:0]    S_BRESP,
    output reg           S_BVALID,
    input  wire          S_BREADY,
    input  wire [4:0]    S_ARADDR,
    input  wire          S_ARVALID,
    output reg           S_ARREADY,
    output reg  [31:0]   S_RDATA,
    output reg  [1:0]    S_RRESP,
    output reg           S_RVALID,
    input  wire          S_RREADY,
    // Flash pins
    output reg  [AW-1:0] F_ADDR,
    input  wire [7:0]    F_DQ_I,
    output reg  [7:0]    F_DQ_O,
    output reg           F_DQ_OE,
    output reg           F_CE_N,
    output reg           F_OE_N,
    output reg           F_WE_N,
    input  wire          F_READY_BUSY_N
);
    localparam S_IDLE = 3'd0, S_WSET = 3'd1, S_WPUL = 3'd2, S_WREC = 3'd3;
    localparam S_RSET = 3'd4, S_RHLD = 3'd5, S_NEXT = 3'd6, S_POLL = 3'd7;

    reg [2:0]    state_r;
    reg [3:0]    op_r;
    reg [2:0]    step_r;
    reg [3:0]    tmr_r;
    reg [AW-1:0] addr_r;
    reg [7:0]    data_r;
    reg [7:0]    rdata_r;
    reg [7:0]    prev_r;
    reg          have_prev_r;
    reg          fail_seen_r;
    reg          busy_r, done_r, fail_r, byp_r, win_r;
    reg [2:0]    rb_s_r;
    reg          rb_r;
    reg          aw_got_r, w_got_r;
    reg [4:0]    awaddr_r;
    reg [31:0]   wdata_r;
    reg          wstrb0_r;
    reg [2:0]    ncyc;
    reg [10:0]   cyc_a;
    reg [7:0]    cyc_d;
    reg          cyc_full;
    reg          cyc_rd;
    reg          poll_after;

    // Command cycle table per operation and step
    always @* begin
        ncyc = 3'd1; cyc_a = `ADDR_555; cyc_d = `CMD_RESET;
        cyc_full = 1'b0; cyc_rd = 1'b0; poll_after = 1'b0;
        case (op_r)
            `OP_RESET: begin
                ncyc = 3'd1; cyc_d = `CMD_RESET;
            end
            `OP_SUSPEND: begin
                ncyc = 3'd1; cyc_d = `CMD_SUSPEND;
            end
            `OP_RESUME: begin
                ncyc = 3'd1; cyc_d = `CMD_SECTOR; poll_after = 1'b1;
            end
            `OP_BYP_PROGRAM: begin
                ncyc = 3'd2; poll_after = 1'b1;
                cyc_d = (step_r == 3'd0) ? `CMD_PROGRAM : data_r;
                cyc_full = (step_r == 3'd1);
            end
            `OP_BYP_EXIT: begin
                ncyc = 3'd2;
                cyc_d = (step_r == 3'd0) ? `CMD_AUTOSEL : `CMD_BYP_EXIT2;
            end
            `OP_SECT_ADD: begin
                ncyc = 3'd1; cyc_d = `CMD_SECTOR; cyc_full = 1'b1; poll_after = 1'b1;
            end
            default: begin
                case (step_r)
                    3'd0: begin cyc_a = `ADDR_555; cyc_d = `CMD_AA; end
                    3'd1: begin cyc_a = `ADDR_2AA; cyc_d = `CMD_55; end
                    3'd2: begin
                        cyc_a = `ADDR_555;
                        case (op_r)
                            `OP_PROGRAM:   cyc_d = `CMD_PROGRAM;
                            `OP_BYP_ENTER: cyc_d = `CMD_BYPASS;
                            `OP_AUTOSEL:   cyc_d = `CMD_AUTOSEL;
                            default:       cyc_d = `CMD_ERASE;
                        endcase
                    end
                    3'd3: begin
                        cyc_a = `ADDR_555; cyc_d = data_r;
                        cyc_full = (op_r != `OP_CHIP_ERASE) && (op_r != `OP_SECT_ERASE);
                        cyc_rd = (op_r == `OP_AUTOSEL);
                        if (op_r == `OP_CHIP_ERASE || op_r == `OP_SECT_ERASE)
                            cyc_d = `CMD_AA;
                    end
                    3'd4: begin cyc_a = `ADDR_2AA; cyc_d = `CMD_55; end
                    default: begin
                        cyc_a = `ADDR_555;
                        cyc_d = (op_r == `OP_CHIP_ERASE) ? `CMD_CHIP : `CMD_SECTOR;
                        cyc_full = (op_r == `OP_SECT_ERASE);
                    end
                endcase
                case (op_r)
                    `OP_PROGRAM:    begin ncyc = 3'd4; poll_after = 1'b1; end
                    `OP_BYP_ENTER:  ncyc = 3'd3;
                    `OP_AUTOSEL:    ncyc = 3'd4;
                    `OP_READ:       begin ncyc = 3'd1; cyc_rd = 1'b1; cyc_full = 1'b1; end
                    default:        begin ncyc = 3'd6; poll_after = 1'b1; end
                endcase
            end
        endcase
    end

    // AXI4-Lite write and read slave
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AWREADY <= 1'b0;
            S_WREADY  <= 1'b0;
            S_BVALID  <= 1'b0;
            S_BRESP   <= 2'b00;
            S_ARREADY <= 1'b0;
            S_RVALID  <= 1'b0;
            S_RRESP   <= 2'b00;
            S_RDATA   <= `RESET_DATA;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= 5'h00;
            wdata_r   <= `RESET_DATA;
            wstrb0_r  <= 1'b0;
            op_r      <= `OP_READ;
            addr_r    <= {AW{1'b0}};
            data_r    <= 8'h00;
        end else begin
            S_AWREADY <= !aw_got_r && S_AWVALID && !S_AWREADY && !S_BVALID;
            S_WREADY  <= !w_got_r && S_WVALID && !S_WREADY && !S_BVALID;
            if (S_AWVALID && S_AWREADY) begin aw_got_r <= 1'b1; awaddr_r <= S_AWADDR; end
            // Strobe kept with the data: the master may move it after the handshake
            if (S_WVALID && S_WREADY) begin
                w_got_r  <= 1'b1;
                wdata_r  <= S_WDATA;
                wstrb0_r <= S_WSTRB[0];
            end
            if (aw_got_r && w_got_r && !S_BVALID) begin
                aw_got_r <= 1'b0; w_got_r <= 1'b0; S_BVALID <= 1'b1; S_BRESP <= 2'b00;
                case (awaddr_r)
                    `REG_CTRL: if (!busy_r && wdata_r[`CTRL_GO_BIT])
                        op_r <= wdata_r[`CTRL_OP_LSB +: `CTRL_OP_W];
                    `REG_ADDR: addr_r <= wdata_r[AW-1:0];
                    `REG_DATA: if (wstrb0_r) data_r <= wdata_r[7:0];
                    `REG_STATUS, `REG_RDATA: S_BRESP <= 2'b00;
                    default: S_BRESP <= 2'b10;
                endcase
            end else if (S_BVALID && S_BREADY) S_BVALID <= 1'b0;
            S_ARREADY <= S_ARVALID && !S_ARREADY && !S_RVALID;
            if (S_ARVALID && S_ARREADY) begin
                S_RVALID <= 1'b1; S_RRESP <= 2'b00; S_RDATA <= `RESET_DATA;
                case (S_ARADDR)
                    `REG_CTRL:   S_RDATA <= {24'h0, op_r, 3'b000, busy_r};
                    `REG_ADDR:   S_RDATA <= {{(32-AW){1'b0}}, addr_r};
                    `REG_DATA:   S_RDATA <= {24'h0, data_r};
                    `REG_STATUS: S_RDATA <= {26'h0, win_r, byp_r, rb_r, fail_r, done_r, busy_r};
                    `REG_RDATA:  S_RDATA <= {24'h0, rdata_r};
                    default:     S_RRESP <= 2'b10;
                endcase
            end else if (S_RVALID && S_RREADY) S_RVALID <= 1'b0;
        end
    end

    wire go_w = aw_got_r && w_got_r && !S_BVALID && awaddr_r == `REG_CTRL
                && !busy_r && wdata_r[`CTRL_GO_BIT];
    wire rb_now = rb_s_r[1] & rb_s_r[2];

    // Flash bus sequencer with toggle polling
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r     <= S_IDLE;
            step_r      <= 3'd0;
            tmr_r       <= 4'h0;
            F_ADDR      <= {AW{1'b0}};
            F_DQ_O      <= 8'h00;
            F_DQ_OE     <= 1'b0;
            F_CE_N      <= 1'b1;
            F_OE_N      <= 1'b1;
            F_WE_N      <= 1'b1;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            fail_r      <= 1'b0;
            byp_r       <= 1'b0;
            win_r       <= 1'b0;
            rdata_r     <= 8'h00;
            prev_r      <= 8'h00;
            have_prev_r <= 1'b0;
            fail_seen_r <= 1'b0;
            rb_s_r      <= 3'b111;
            rb_r        <= 1'b1;
        end else begin
            rb_s_r <= {rb_s_r[1:0], F_READY_BUSY_N};
            if (rb_s_r[1] == rb_s_r[2]) rb_r <= rb_now;
            if (tmr_r != 4'h0) tmr_r <= tmr_r - 4'h1;
            case (state_r)
                S_IDLE: if (go_w) begin
                    busy_r <= 1'b1; done_r <= 1'b0; fail_r <= 1'b0; step_r <= 3'd0;
                    have_prev_r <= 1'b0; fail_seen_r <= 1'b0;
                    state_r <= S_NEXT;
                end
                S_NEXT: begin
                    // Upper bits zero unless the cycle carries a full address
                    F_ADDR <= cyc_full ? addr_r : {{(AW-11){1'b0}}, cyc_a};
                    if (op_r == `OP_AUTOSEL && step_r == 3'd3)
                        F_ADDR <= addr_r;
                    F_DQ_O <= cyc_d; tmr_r <= `T_PHASE_CYC;
                    F_CE_N <= 1'b0;
                    F_DQ_OE <= !cyc_rd;
                    state_r <= cyc_rd ? S_RSET : S_WSET;
                end
                S_WSET: if (tmr_r == 4'h0) begin
                    F_WE_N <= 1'b0; tmr_r <= `T_PHASE_CYC;
                    state_r <= S_WPUL;
                end
                S_WPUL: if (tmr_r == 4'h0) begin
                    F_WE_N <= 1'b1; tmr_r <= `T_PHASE_CYC;
                    state_r <= S_WREC;
                end
                S_WREC: if (tmr_r == 4'h0) begin
                    // Data and address held past the rising edge
                    F_CE_N <= 1'b1; F_DQ_OE <= 1'b0;
                    if (step_r + 3'd1 < ncyc) begin
                        step_r <= step_r + 3'd1; state_r <= S_NEXT;
                    end else if (poll_after) begin
                        F_ADDR <= addr_r;
                        state_r <= S_POLL;
                    end else begin
                        if (op_r == `OP_BYP_ENTER) byp_r <= 1'b1;
                        // Plain reset leaves bypass mode in force
                        if (op_r == `OP_BYP_EXIT) byp_r <= 1'b0;
                        busy_r <= 1'b0; done_r <= 1'b1; state_r <= S_IDLE;
                    end
                end
                S_POLL: begin
                    F_CE_N <= 1'b0; F_OE_N <= 1'b0; tmr_r <= `T_PHASE_CYC;
                    state_r <= S_RSET;
                end
                S_RSET: begin
                    F_OE_N <= 1'b0;
                    if (tmr_r == 4'h0) begin
                        rdata_r <= F_DQ_I;
                        F_OE_N <= 1'b1; F_CE_N <= 1'b1; state_r <= S_RHLD;
                        tmr_r <= `T_PHASE_CYC;
                    end
                end
                S_RHLD: if (tmr_r == 4'h0) begin
                    if (!poll_after || (op_r == `OP_AUTOSEL)) begin
                        busy_r <= 1'b0; done_r <= 1'b1; state_r <= S_IDLE;
                    end else if (!have_prev_r) begin
                        prev_r <= rdata_r; have_prev_r <= 1'b1; state_r <= S_POLL;
                    end else if (prev_r[6] == rdata_r[6]) begin
                        // Toggle stopped; this second read already holds settled data
                        win_r <= rdata_r[3];
                        if (op_r == `OP_SECT_ERASE || op_r == `OP_SECT_ADD) win_r <= 1'b0;
                        busy_r <= 1'b0; done_r <= 1'b1; state_r <= S_IDLE;
                    end else if (rdata_r[5] || fail_seen_r) begin
                        if (fail_seen_r) begin
                            fail_r <= 1'b1; busy_r <= 1'b0;
                            state_r <= S_IDLE;
                        end else begin
                            fail_seen_r <= 1'b1; prev_r <= rdata_r; state_r <= S_POLL;
                        end
                    end else begin
                        prev_r <= rdata_r; win_r <= rdata_r[3]; state_r <= S_POLL;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // flash_ctl

// ---- dv/flash_ctl_properties.sv ----
// Checker for the flash host controller: strobe shapes and AXI answers.
// Bound to flash_ctl from tb_top; sees only its ports.
`timescale 1ns/1ps
module flash_ctl_props #(parameter AW = 19) (
    input wire MCLK, input wire ARST_N,
    input wire [4:0] S_AWADDR, input wire S_AWVALID, input wire S_AWREADY,
    input wire [31:0] S_WDATA, input wire [3:0] S_WSTRB, input wire S_WVALID,
    input wire S_WREADY, input wire [1:0] S_BRESP, input wire S_BVALID, input wire S_BREADY,
    input wire [4:0] S_ARADDR, input wire S_ARVALID, input wire S_ARREADY,
    input wire [31:0] S_RDATA, input wire [1:0] S_RRESP, input wire S_RVALID,
    input wire S_RREADY, input wire [AW-1:0] F_ADDR, input wire [7:0] F_DQ_I,
    input wire [7:0] F_DQ_O, input wire F_DQ_OE, input wire F_CE_N, input wire F_OE_N,
    input wire F_WE_N, input wire F_READY_BUSY_N
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    sequence we_low3; !F_WE_N [*3]; endsequence
    sequence aw_taken; S_AWVALID && S_AWREADY; endsequence
    a_we_in_ce: assert property (!F_WE_N |-> !F_CE_N)
        else $error("write strobe outside chip select");
    a_addr_setup: assert property ($fell(F_WE_N) |-> $stable(F_ADDR) && F_DQ_OE)
        else $error("address moved at write strobe fall");
    a_data_hold: assert property (
        $rose(F_WE_N) |-> $stable(F_DQ_O) && F_DQ_OE && !F_CE_N)
        else $error("data not held across strobe rise");
    a_we_width: assert property ($fell(F_WE_N) |-> we_low3 ##1 F_WE_N)
        else $error("write strobe width wrong");
    a_read_clean: assert property (!F_OE_N |-> !F_DQ_OE && !F_CE_N && F_WE_N)
        else $error("read strobe with bus driven");
    a_bvalid_hold: assert property (S_BVALID && !S_BREADY |=> S_BVALID)
        else $error("write response dropped");
    a_rdata_hold: assert property (S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
        else $error("read data dropped");
    a_b_answer: assert property (aw_taken |-> ##[1:4] S_BVALID)
        else $error("write response late");
    a_r_answer: assert property (S_ARVALID && S_ARREADY |=> S_RVALID)
        else $error("read response late");
endmodule // flash_ctl_props

// ---- dv/flash_model.sv ----
// Behavioural boot-sector flash: command decode, status bits, open-drain busy.
// Assumes controller strobes; busy lasts NB status reads rather than real time.
`timescale 1ns/1ps
module flash_model #(parameter [5:0] PROT = 6'h3f, parameter NB = 4) (
    input  wire [18:0] addr,
    input  wire        ce_n,
    input  wire        oe_n,
    input  wire        we_n,
    input  wire [7:0]  din,
    input  wire        fail_en,
    output wire [7:0]  dout,
    output wire        rb_low
);
    reg [7:0] mem [0:255];
    reg [18:0] la;
    reg [7:0] pd, last;
    reg [5:0] es;
    reg [3:0] bc;
    reg [2:0] cyc, md;
    reg act, pg, tg, fl;
    integer i;
    wire [7:0] st = {pg ? ~pd[7] : 1'b0, tg, fl, 1'b0, !pg, !pg && addr[18:13] == es && tg,
        2'b0};
    wire [7:0] rd = bc != 0 ? st : md == 1 ?
        {7'h0, addr[7:0] == 8'h02 && addr[18:13] == PROT} : mem[addr[7:0]];
    // Released bus shows the inverse, never a stale byte
    assign dout = !ce_n && !oe_n ? rd : ~last;
    assign rb_low = bc != 0;
    initial begin
        for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
        {act, pg, tg, fl, bc, cyc, md, last, es, pd} = 0;
    end
    always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
        la = addr;
        act = 1;
    end
    always @(posedge we_n or posedge ce_n) if (act) begin act = 0; wr(la, din); end
    always @(posedge oe_n) begin
        last = rd;
        if (bc != 0) begin tg = ~tg; if (!fl) bc = bc - 1; end
    end
    task wr(input [18:0] a, input [7:0] d);
        if (d == 8'hf0 && md != 3 && (bc == 0 || fl)) begin
            md = 0;
            cyc = 0;
            bc = 0;
            fl = 0;
        end
        else if (bc != 0) ;
        else if (md == 2 || md == 4) begin
            if (a[18:13] != PROT) mem[a[7:0]] = mem[a[7:0]] & d;
            pd = d; pg = 1; fl = fail_en; bc = NB; md = md == 4 ? 3 : 0;
        end else if (md == 3) md = d == 8'ha0 ? 4 : d == 8'h90 ? 5 : 3;
        else if (md == 5) md = d == 8'h00 ? 0 : 3;
        else if (cyc == 0 || cyc == 3)
            cyc = d == 8'haa && a[10:0] == 11'h555 ? cyc + 1 : 0;
        else if (cyc == 1 || cyc == 4) cyc = d == 8'h55 && a[10:0] == 11'h2aa ? cyc + 1 : 0;
        else if (cyc == 2) begin
            cyc = d == 8'h80 ? 3 : 0;
            md = d == 8'h90 ? 1 : d == 8'ha0 ? 2 : d == 8'h20 ? 3 : md;
        end else begin
            // Lone resume or suspend never reaches here
            cyc = 0; es = a[18:13]; pg = 0; bc = NB; fl = fail_en;
            if (d == 8'h10 || a[18:13] != PROT) for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
        end
    endtask
endmodule // flash_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the flash host controller over AXI4-Lite.
// Assumes the behavioural flash on the pins and a pull-up on ready/busy.
`timescale 1ns/1ps
`include "flash_ctl_defs.vh"
module tb_top;
    localparam AW = 19;
    localparam [5:0] PROT = 6'h3f;
    reg MCLK, ARST_N, awv, wv, bry, arv, rry, fail_en, saw_low;
    reg [4:0] awa, ara;
    reg [31:0] wd, rd, st;
    reg [1:0] rsp;
    reg [7:0] expm [0:255];
    reg [18:0] a;
    reg [7:0] d;
    integer failures, checks_done, cyc, i, n, seed;
    wire [31:0] rdat;
    wire [1:0] brsp, rrsp;
    wire awr, wrd, bv, arr, rv, ce_n, oe_n, we_n, oe, rbl;
    wire [18:0] fa;
    wire [7:0] dq_o, dq_i;
    wire [7:0] bus = oe ? dq_o : dq_i;
    wire rb_n = rbl ? 1'b0 : 1'b1;
    flash_ctl #(.AW(AW)) dut (.MCLK(MCLK), .ARST_N(ARST_N), .S_AWADDR(awa), .S_AWVALID(awv),
        .S_AWREADY(awr), .S_WDATA(wd), .S_WSTRB(4'hf), .S_WVALID(wv), .S_WREADY(wrd),
        .S_BRESP(brsp), .S_BVALID(bv), .S_BREADY(bry), .S_ARADDR(ara), .S_ARVALID(arv),
        .S_ARREADY(arr), .S_RDATA(rdat), .S_RRESP(rrsp), .S_RVALID(rv), .S_RREADY(rry),
        .F_ADDR(fa), .F_DQ_I(dq_i), .F_DQ_O(dq_o), .F_DQ_OE(oe), .F_CE_N(ce_n),
        .F_OE_N(oe_n), .F_WE_N(we_n), .F_READY_BUSY_N(rb_n));
    flash_model #(.PROT(PROT), .NB(4)) flash (.addr(fa), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .din(bus), .fail_en(fail_en), .dout(dq_i), .rb_low(rbl));
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Readies sampled mid-cycle, so the handshake edge is known before it comes
    task axw(input [4:0] ad, input [31:0] dt);
        reg ta, tw, tb;
        @(posedge MCLK); awa <= ad; wd <= dt; awv <= 1; wv <= 1; tb = 0;
        // Ready held back on some calls so the slave must keep its answer
        bry <= 1'($urandom_range(1));
        while (!tb) begin
            @(negedge MCLK); ta = awv & awr; tw = wv & wrd; tb = bv & bry; rsp = brsp;
            @(posedge MCLK); if (ta) awv <= 0; if (tw) wv <= 0;
            if (tb) bry <= 0;
            else if (bv) bry <= 1;
        end
    endtask
    task axr(input [4:0] ad);
        reg ta, tr;
        @(posedge MCLK); ara <= ad; arv <= 1; tr = 0;
        rry <= 1'($urandom_range(1));
        while (!tr) begin
            @(negedge MCLK); ta = arv & arr; tr = rv & rry; rd = rdat; rsp = rrsp;
            @(posedge MCLK); if (ta) arv <= 0;
            if (tr) rry <= 0;
            else if (rv) rry <= 1;
        end
    endtask
    task op(input [3:0] o, input [18:0] ad, input [7:0] dt);
        axw(`REG_ADDR, {13'h0, ad}); axw(`REG_DATA, {24'h0, dt});
        axw(`REG_CTRL, {24'h0, o, 4'h1});
        st = 1;
        while (st[0]) begin axr(`REG_STATUS); st = rd; end
        axr(`REG_RDATA);
    endtask
    function [7:0] pgm(input [18:0] ad, input [7:0] dt);
        pgm = ad[18:13] == PROT ? expm[ad[7:0]] : expm[ad[7:0]] & dt;
    endfunction
    task prog(input [3:0] o, input [18:0] ad, input [7:0] dt);
        saw_low = 0; expm[ad[7:0]] = pgm(ad, dt);
        op(o, ad, dt);
        chk("prog status", st & 32'h7, 32'h2);
        chk("poll data", rd, {24'h0, expm[ad[7:0]]});
        chk("busy pin", saw_low, 1);
        op(`OP_READ, ad, 0);
        chk("read back", rd, {24'h0, expm[ad[7:0]]});
    endtask
    task ers(input [3:0] o, input [18:0] ad);
        op(o, ad, 0);
        chk("erase status", st & 32'h7, 32'h2);
        if (o == `OP_CHIP_ERASE || ad[18:13] != PROT) for (i = 0; i < 256; i++) expm[i] = 8'hff;
        op(`OP_READ, a, 0);
        chk("after erase", rd, {24'h0, expm[a[7:0]]});
    endtask
    initial begin
        MCLK = 0;
        forever #25 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (rb_n === 1'b0) saw_low <= 1;
        if (cyc == 40000) begin failures = failures + 1; end_sim; end
    end
    initial begin
        {ARST_N, awv, wv, bry, arv, rry, fail_en, saw_low, awa, ara, wd} = 0;
        failures = 0; checks_done = 0; cyc = 0;
        for (i = 0; i < 256; i++) expm[i] = 8'hff;
        seed = $urandom(32'hc3d27bd6);
        repeat (3) @(posedge MCLK);
        ARST_N <= 1;
        axr(`REG_STATUS); chk("idle status", rd, 32'h8);
        axr(5'h14); chk("unmapped read", rsp, 2'b10);
        axw(5'h14, 0); chk("unmapped write", rsp, 2'b10);
        axw(`REG_ADDR, 32'h00075a5a); chk("write okay", rsp, 2'b00);
        axr(`REG_ADDR); chk("addr reg", rd, 32'h00075a5a);
        axw(`REG_DATA, 32'h123456c3); axr(`REG_DATA); chk("data reg", rd, 32'h000000c3);
        $display("test registers done");
        for (n = 0; n < 8; n++) begin
            a = {6'($urandom_range(62)), 13'($urandom)}; d = $urandom;
            if (n == 0) begin a = 0; d = 0; end
            if (n == 1) begin a = 19'h7dfff; d = 8'hff; end
            prog(`OP_PROGRAM, a, d);
        end
        prog(`OP_PROGRAM, {PROT, 13'h0055}, 8'h00);
        $display("test program done");
        op(`OP_BYP_ENTER, 0, 0); chk("bypass on", st[4], 1);
        op(`OP_RESET, 0, 0); chk("bypass held", st[4], 1);
        prog(`OP_BYP_PROGRAM, a ^ 19'h00f0, 8'h5a);
        op(`OP_BYP_EXIT, 0, 0); chk("bypass off", st[4], 0);
        op(`OP_AUTOSEL, {PROT, 5'h0, 8'h02}, 0); chk("locked sector", rd, 1);
        op(`OP_RESET, 0, 0);
        op(`OP_AUTOSEL, {6'h01, 5'h0, 8'h02}, 0); chk("open sector", rd, 0);
        op(`OP_RESET, 0, 0);
        op(`OP_SUSPEND, 0, 0); op(`OP_RESUME, a, 0); op(`OP_SECT_ADD, a, 0);
        op(`OP_READ, a, 0); chk("idle resume", rd, {24'h0, expm[a[7:0]]});
        $display("test modes done");
        ers(`OP_SECT_ERASE, {PROT, 13'h0});
        ers(`OP_SECT_ERASE, {6'h05, 13'h0});
        prog(`OP_PROGRAM, a, 8'h3c);
        ers(`OP_CHIP_ERASE, 0);
        $display("test erase done");
        fail_en <= 1;
        op(`OP_PROGRAM, a ^ 19'h1, 8'h00);
        fail_en <= 0;
        chk("fail status", st & 32'h5, 32'h4);
        op(`OP_RESET, 0, 0);
        op(`OP_READ, a, 0); chk("after reset", rd, {24'h0, expm[a[7:0]]});
        $display("test failure done");
        end_sim;
    end
endmodule // tb_top
bind flash_ctl flash_ctl_props #(.AW(AW)) props (.*);
